// ### rtl/cpw_pkg.sv
/*
  constants for the compare and pwm unit: register indices, field
  positions, reset values, mode codes and timing counts.
  assumes a 32-bit ahb-lite bus where byte address = 4 * index.
*/
package cpw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_T16_LO    = 8'h0E;
  localparam logic [7:0] IDX_T16_HI    = 8'h0F;
  localparam logic [7:0] IDX_TB_COUNT  = 8'h11;
  localparam logic [7:0] IDX_TB_CTRL   = 8'h12;
  localparam logic [7:0] IDX_CMP_LO    = 8'h13;
  localparam logic [7:0] IDX_CMP_HI    = 8'h14;
  localparam logic [7:0] IDX_UNIT_CTRL = 8'h15;
  localparam logic [7:0] IDX_IRQ_EN    = 8'h8C;
  localparam logic [7:0] IDX_PERIOD    = 8'h92;
  localparam int         IDX_LSB       = 2;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FLAG_UNIT   = 5;
  localparam int FLAG_TB     = 1;
  localparam int FLAG_T16    = 0;
  localparam int CTRL_DC_LSB = 4;
  localparam int TBC_ON      = 2;
  localparam int TBC_POS_LSB = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] CTRL_MASK  = 8'h3F;
  localparam logic [7:0] TBC_MASK   = 8'h7F;

  ////////////////////////////////////////////////////////////////////////////
  // unit mode codes
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_SET     = 4'h8;
  localparam logic [3:0] MODE_CLEAR   = 4'h9;
  localparam logic [3:0] MODE_SWIRQ   = 4'hA;
  localparam logic [3:0] MODE_SPECIAL = 4'hB;
  localparam logic [1:0] MODE_PWM_HI  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // timing: one instruction cycle is four oscillator periods of MCLK
  localparam int         MCLK_PERIOD_NS = 20;
  localparam int         INSTR_TOSC     = 4;
  localparam logic [1:0] QUARTER_LAST   = 2'(INSTR_TOSC - 1);
  localparam logic [3:0] PRE_TERM_1     = 4'h0;
  localparam logic [3:0] PRE_TERM_4     = 4'h3;
  localparam logic [3:0] PRE_TERM_16    = 4'hF;

endpackage : cpw_pkg

// ### rtl/cpw_reset_sync.sv
/*
  reset release synchroniser: asynchronous assert, two-flop release.
  assumes rst_n_in may drop at any time relative to clk.
*/
`timescale 1ns/1ps
module cpw_reset_sync (
  // clock and raw reset
  input  wire logic clk,
  input  wire logic rst_n_in,
  // synchronised reset
  output logic      rst_n_out
);

  logic stage_reg;

  // two-flop release chain
  always_ff @(posedge clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_reg <= 1'b0;
      rst_n_out <= 1'b0;
    end else begin
      stage_reg <= 1'b1;
      rst_n_out <= stage_reg;
    end
  end

endmodule : cpw_reset_sync

// ### rtl/cpw_timebase.sv
/*
  8-bit pwm timebase with 1/4/16 prescaler and quarter-cycle counter.
  assumes clk is the oscillator clock; one quarter step per prescale.
*/
`timescale 1ns/1ps
module cpw_timebase (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       run,
  input  wire logic [1:0] presc_sel,
  input  wire logic       clear_pre,
  input  wire logic       load_en,
  input  wire logic [7:0] load_val,
  input  wire logic [7:0] period,
  // state
  output logic      [7:0] count,
  output logic      [1:0] quarter,
  output logic            period_hit
);

  logic [3:0] pre_cnt_reg;
  logic [3:0] pre_term;
  logic       fine_tick;
  logic       inc;

  // prescale select 1, 4 or 16
  always_comb begin
    case (presc_sel)
      2'h0:    pre_term = cpw_pkg::PRE_TERM_1;  // R23
      2'h1:    pre_term = cpw_pkg::PRE_TERM_4;
      default: pre_term = cpw_pkg::PRE_TERM_16;
    endcase
  end

  assign fine_tick  = run && (pre_cnt_reg >= pre_term);
  assign inc        = fine_tick && (quarter == cpw_pkg::QUARTER_LAST);
  assign period_hit = inc && (count == period);  // R14

  // prescaler counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_reg <= 4'h0;
    end else if (clear_pre || fine_tick) begin
      pre_cnt_reg <= 4'h0;
    end else if (run) begin
      pre_cnt_reg <= pre_cnt_reg + 4'h1;
    end
  end

  // quarter-cycle counter, low two bits of the 10-bit time base
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quarter <= 2'h0;
    end else if (clear_pre) begin
      quarter <= 2'h0;
    end else if (fine_tick) begin
      quarter <= quarter + 2'h1;
    end
  end

  // 8-bit count, cleared on the increment after a period match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
    end else if (load_en) begin
      count <= load_val;
    end else if (period_hit) begin
      count <= 8'h00;  // R14
    end else if (inc) begin
      count <= count + 8'h01;
    end
  end

endmodule : cpw_timebase

// ### rtl/cpw_compare_pwm_unit.sv
/*
  compare and pwm unit with its 16-bit timer, pwm timebase and an
  ahb-lite register slave. assumes TIMER16_TICK is a one-cycle pulse
  per timer clock rising edge, synchronous to MCLK.
*/
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// How it works
// [R1] software interrupt mode: flag only, pin untouched
// [R2] special event mode emits hardware trigger pulse
// [R3] trigger fires at once on 16-bit equality
// [R4] timer cleared at next timer clock edge
// [R5] trigger starts conversion when converter enabled
// [R6] trigger reset never sets timer overflow flag
// [R7] match removed before edge cancels timer reset
// [R8] control write zero forces compare latch low
// [R9] control write zero forces pwm latch inactive
// [R10] software keeps timer in synchronous mode
// [R11] software sets pin direction to output
// [R12] pwm output with up to ten-bit duty
// [R13] period is (period+1) * 4 * prescale clocks
// [R14] after period match: clear, set pin unless new duty is zero, load duty
// [R15] postscaler does not affect pwm period
// [R16] duty is low register plus control bits 5:4
// [R17] duty writes take effect at period match
// [R18] compare high read-only in pwm mode
// [R19] pin cleared when duty equals fine time base
// [R20] duty beyond period leaves pin set
// [R21] resolution is log2 of 4*(period+1)
// [R22] new waveform starts after timebase reset
// [R23] prescale selectable as 1, 4 or 16
// [R24] set, clear, toggle pin modes also flag
// [R25] pwm modes with high or low true output
// [R26] mode zero turns unit off and resets
// [R27] compare register checked continuously against timer
module cpw_compare_pwm_unit (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // timer and converter links
  input  wire logic        TIMER16_TICK,
  input  wire logic        ADC_ENABLE,
  output logic             SPECIAL_TRIGGER,
  output logic             ADC_START,
  // pin and interrupt request
  output logic             COMPARE_PWM_OUT,
  output logic             UNIT_IRQ
);

  logic        rst_n;
  logic        sel_reg;
  logic        wr_reg;
  logic [7:0]  idx_reg;
  logic [7:0]  wdata;
  logic        addr_ok;
  logic        wr_flags, wr_t16lo, wr_t16hi, wr_tbcnt, wr_tbctrl;
  logic        wr_cmplo, wr_cmphi, wr_ctrl, wr_irqen, wr_period;
  logic [7:0]  flags_reg, irqen_reg, ctrl_reg, tbctrl_reg, period_reg;
  logic [7:0]  cmp_lo_reg, cmp_hi_reg;
  logic [15:0] t16_reg;
  logic [1:0]  dc_latch_reg;
  logic [3:0]  post_cnt_reg;
  logic        match_d_reg, pending_reg;
  logic        cmp_out_reg, pwm_out_reg, pin_reg, irq_reg;
  logic [7:0]  rd_next;
  logic [3:0]  mode;
  logic        pwm_mode, cmp_mode, match, hit, trig;
  logic [7:0]  tb_count;
  logic [1:0]  tb_quarter;
  logic        period_hit;
  logic [9:0]  duty_act, duty_next;
  logic        t16_reset, t16_ovf, post_hit, duty_eq;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  cpw_reset_sync u_rst (
    .clk       (MCLK),
    .rst_n_in  (RESETN),
    .rst_n_out (rst_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture, zero wait states
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= 1'b0;
      wr_reg  <= 1'b0;
      idx_reg <= 8'h00;
    end else if (HREADY) begin
      sel_reg <= HSEL && HTRANS[1];
      wr_reg  <= HWRITE;
      idx_reg <= HADDR[cpw_pkg::IDX_LSB +: 8];
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign wdata     = HWDATA[7:0];
  assign addr_ok   = sel_reg && wr_reg;

  // write strobes in the data phase
  assign wr_flags  = addr_ok && (idx_reg == cpw_pkg::IDX_IRQ_FLAGS);
  assign wr_t16lo  = addr_ok && (idx_reg == cpw_pkg::IDX_T16_LO);
  assign wr_t16hi  = addr_ok && (idx_reg == cpw_pkg::IDX_T16_HI);
  assign wr_tbcnt  = addr_ok && (idx_reg == cpw_pkg::IDX_TB_COUNT);
  assign wr_tbctrl = addr_ok && (idx_reg == cpw_pkg::IDX_TB_CTRL);
  assign wr_cmplo  = addr_ok && (idx_reg == cpw_pkg::IDX_CMP_LO);
  assign wr_cmphi  = addr_ok && (idx_reg == cpw_pkg::IDX_CMP_HI);
  assign wr_ctrl   = addr_ok && (idx_reg == cpw_pkg::IDX_UNIT_CTRL);
  assign wr_irqen  = addr_ok && (idx_reg == cpw_pkg::IDX_IRQ_EN);
  assign wr_period = addr_ok && (idx_reg == cpw_pkg::IDX_PERIOD);

  // read mux, unmapped reads as zero
  always_comb begin
    case (HADDR[cpw_pkg::IDX_LSB +: 8])
      cpw_pkg::IDX_IRQ_FLAGS: rd_next = flags_reg;
      cpw_pkg::IDX_T16_LO:    rd_next = t16_reg[7:0];
      cpw_pkg::IDX_T16_HI:    rd_next = t16_reg[15:8];
      cpw_pkg::IDX_TB_COUNT:  rd_next = tb_count;
      cpw_pkg::IDX_TB_CTRL:   rd_next = tbctrl_reg;
      cpw_pkg::IDX_CMP_LO:    rd_next = cmp_lo_reg;
      cpw_pkg::IDX_CMP_HI:    rd_next = cmp_hi_reg;
      cpw_pkg::IDX_UNIT_CTRL: rd_next = ctrl_reg;
      cpw_pkg::IDX_IRQ_EN:    rd_next = irqen_reg;
      cpw_pkg::IDX_PERIOD:    rd_next = period_reg;
      default:                rd_next = 8'h00;
    endcase
  end

  // read data registered at the end of the address phase
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA <= 32'h00000000;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      HRDATA <= {24'h000000, rd_next};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // plain control registers
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg   <= cpw_pkg::RST_BYTE;
      irqen_reg  <= cpw_pkg::RST_BYTE;
      tbctrl_reg <= cpw_pkg::RST_BYTE;
      period_reg <= cpw_pkg::RST_PERIOD;
      cmp_lo_reg <= cpw_pkg::RST_BYTE;
    end else begin
      if (wr_ctrl) ctrl_reg <= wdata & cpw_pkg::CTRL_MASK;  // R16
      if (wr_irqen) irqen_reg <= wdata;
      if (wr_tbctrl) tbctrl_reg <= wdata & cpw_pkg::TBC_MASK;
      if (wr_period) period_reg <= wdata;
      if (wr_cmplo) cmp_lo_reg <= wdata;  // R17
    end
  end

  assign mode     = ctrl_reg[3:0];
  assign pwm_mode = (mode[3:2] == cpw_pkg::MODE_PWM_HI);  // R25
  assign cmp_mode = (mode == cpw_pkg::MODE_TOGGLE) ||
                    (mode == cpw_pkg::MODE_SET) ||
                    (mode == cpw_pkg::MODE_CLEAR) ||
                    (mode == cpw_pkg::MODE_SWIRQ) ||
                    (mode == cpw_pkg::MODE_SPECIAL);

  ////////////////////////////////////////////////////////////////////////////
  // compare engine
  assign match = (t16_reg == {cmp_hi_reg, cmp_lo_reg});  // R27
  assign hit   = cmp_mode && match && !match_d_reg;
  assign trig  = hit && (mode == cpw_pkg::MODE_SPECIAL);  // R2 R3
  assign SPECIAL_TRIGGER = trig;
  assign ADC_START       = trig && ADC_ENABLE;  // R5

  // edge memory of the match and reset-pending flag
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      match_d_reg <= 1'b0;
      pending_reg <= 1'b0;
    end else begin
      match_d_reg <= match;
      if (mode == cpw_pkg::MODE_OFF) begin
        pending_reg <= 1'b0;  // R26
      end else if (trig) begin
        pending_reg <= 1'b1;
      end else if (TIMER16_TICK) begin
        pending_reg <= 1'b0;  // R7
      end
    end
  end

  // reset only if the match still stands at the timer edge
  assign t16_reset = TIMER16_TICK && pending_reg && match;  // R4 R7
  assign t16_ovf   = TIMER16_TICK && !t16_reset && (t16_reg == 16'hFFFF);

  // 16-bit timer, software writes win over counting
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      t16_reg <= 16'h0000;
    end else if (wr_t16lo) begin
      t16_reg[7:0] <= wdata;
    end else if (wr_t16hi) begin
      t16_reg[15:8] <= wdata;
    end else if (t16_reset) begin
      t16_reg <= 16'h0000;  // R4
    end else if (TIMER16_TICK) begin
      t16_reg <= t16_reg + 16'h0001;
    end
  end

  // compare output latch
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      cmp_out_reg <= 1'b0;
    end else if (mode == cpw_pkg::MODE_OFF) begin
      cmp_out_reg <= 1'b0;  // R8 R26
    end else if (hit) begin
      case (mode)
        cpw_pkg::MODE_SET:    cmp_out_reg <= 1'b1;  // R24
        cpw_pkg::MODE_CLEAR:  cmp_out_reg <= 1'b0;
        cpw_pkg::MODE_TOGGLE: cmp_out_reg <= !cmp_out_reg;
        default:              cmp_out_reg <= cmp_out_reg;  // R1
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm timebase
  cpw_timebase u_tb (
    .clk        (MCLK),
    .rst_n      (rst_n),
    .run        (tbctrl_reg[cpw_pkg::TBC_ON]),
    .presc_sel  (tbctrl_reg[1:0]),
    .clear_pre  (wr_tbcnt || wr_tbctrl),
    .load_en    (wr_tbcnt),
    .load_val   (wdata),
    .period     (period_reg),
    .count      (tb_count),
    .quarter    (tb_quarter),
    .period_hit (period_hit)
  );

  assign duty_next = {cmp_lo_reg, ctrl_reg[cpw_pkg::CTRL_DC_LSB +: 2]};
  assign duty_act  = {cmp_hi_reg, dc_latch_reg};  // R16
  assign duty_eq   = ({tb_count, tb_quarter} == duty_act);  // R19
  // double-buffered duty, high byte read-only while in pwm mode
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      cmp_hi_reg   <= cpw_pkg::RST_BYTE;
      dc_latch_reg <= 2'h0;
    end else if (pwm_mode) begin
      if (period_hit) begin
        cmp_hi_reg   <= cmp_lo_reg;  // R17 R14
        dc_latch_reg <= ctrl_reg[cpw_pkg::CTRL_DC_LSB +: 2];
      end
    end else if (wr_cmphi) begin
      cmp_hi_reg <= wdata;  // R18
    end
  end

  // pwm output latch; period match sets unless new duty is zero, 10-bit duty equality clears
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pwm_out_reg <= 1'b0;
    end else if (!pwm_mode) begin
      pwm_out_reg <= 1'b0;  // R9
    end else if (period_hit) begin
      pwm_out_reg <= (duty_next != 10'h000);  // R14 R22
    end else if (duty_eq) begin
      pwm_out_reg <= 1'b0;  // R19 R20 R21 R12 R13
    end
  end

  // postscaler feeds only the timebase flag
  assign post_hit = period_hit &&
                    (post_cnt_reg == tbctrl_reg[cpw_pkg::TBC_POS_LSB +: 4]);
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      post_cnt_reg <= 4'h0;
    end else if (wr_tbcnt || wr_tbctrl || post_hit) begin
      post_cnt_reg <= 4'h0;  // R15
    end else if (period_hit) begin
      post_cnt_reg <= post_cnt_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags: hardware set wins over software clear
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= cpw_pkg::RST_BYTE;
    end else begin
      if (wr_flags) flags_reg <= wdata;
      if (hit) flags_reg[cpw_pkg::FLAG_UNIT] <= 1'b1;  // R1 R24
      if (post_hit) flags_reg[cpw_pkg::FLAG_TB] <= 1'b1;
      if (t16_ovf) flags_reg[cpw_pkg::FLAG_T16] <= 1'b1;  // R6
    end
  end

  // registered pin, duty equality drops it at once so high time is exact
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      pin_reg <= pwm_mode ? (pwm_out_reg & ~duty_eq ^ mode[1]) : cmp_out_reg;
      irq_reg <= flags_reg[cpw_pkg::FLAG_UNIT] &&
                 irqen_reg[cpw_pkg::FLAG_UNIT];  // R1
    end
  end

  assign COMPARE_PWM_OUT = pin_reg;
  assign UNIT_IRQ        = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_swirq_pin_hold: assert property (@(posedge MCLK) disable iff (!rst_n)
    (hit && mode == cpw_pkg::MODE_SWIRQ) |=> $stable(cmp_out_reg)) // R1
    else $error("software interrupt mode changed the pin latch");

  a_hit_sets_flag: assert property (@(posedge MCLK) disable iff (!rst_n)
    hit |=> flags_reg[cpw_pkg::FLAG_UNIT]) // R24
    else $error("compare hit did not set unit flag");

  a_special_fires: assert property (@(posedge MCLK) disable iff (!rst_n)
    (mode == cpw_pkg::MODE_SPECIAL && match && !match_d_reg)
      |-> SPECIAL_TRIGGER ##1 !SPECIAL_TRIGGER) // R2
    else $error("special trigger missing or longer than one cycle");

  a_adc_started: assert property (@(posedge MCLK) disable iff (!rst_n)
    ADC_START == (SPECIAL_TRIGGER && ADC_ENABLE)) // R5
    else $error("conversion start does not follow trigger");

  a_timer_cleared: assert property (@(posedge MCLK) disable iff (!rst_n)
    (TIMER16_TICK && pending_reg && match && !wr_t16lo && !wr_t16hi)
      |=> t16_reg == 16'h0000) // R4
    else $error("timer not cleared on the edge after trigger");

  a_no_ovf_trig: assert property (@(posedge MCLK) disable iff (!rst_n)
    (t16_reset && !flags_reg[cpw_pkg::FLAG_T16] && !wr_flags)
      |=> !flags_reg[cpw_pkg::FLAG_T16]) // R6
    else $error("trigger reset set the overflow flag");

  a_off_pin_low: assert property (@(posedge MCLK) disable iff (!rst_n)
    (mode == cpw_pkg::MODE_OFF && !wr_ctrl) [*2]
      |-> !cmp_out_reg && !pwm_out_reg ##1 !COMPARE_PWM_OUT) // R8
    else $error("unit off but output latch not low");

  a_period_sets: assert property (@(posedge MCLK) disable iff (!rst_n)
    (pwm_mode && period_hit && duty_next != 10'h000)
      |=> pwm_out_reg && duty_act == $past(duty_next)) // R14
    else $error("period match did not set pin and load duty");

  a_duty_clears: assert property (@(posedge MCLK) disable iff (!rst_n)
    (pwm_mode && !period_hit && {tb_count, tb_quarter} == duty_act)
      |=> !pwm_out_reg) // R19
    else $error("duty equality did not clear pwm latch");

  a_high_readonly: assert property (@(posedge MCLK) disable iff (!rst_n)
    (pwm_mode && wr_cmphi && !period_hit) |=> $stable(cmp_hi_reg)) // R18
    else $error("compare high written in pwm mode");

endmodule : cpw_compare_pwm_unit

// ### test/cpw_pin_load.sv
/*
  load on the compare/pwm pin: measures high time and period.
  assumes pin is sampled on the rising clock edge.
*/
`timescale 1ns/1ps
module cpw_pin_load (
  // clock and observed pin
  input  wire logic        clk,
  input  wire logic        pin,   // pin direction set to output
  // measured figures in clock cycles
  output logic      [15:0] hi_len,
  output logic      [15:0] per_len
);
  logic        prev_pin;
  logic [15:0] span;
  ////////////////////////////////////////////////////////////////////////////
  // time since the last rising edge of the pin
  initial begin
    prev_pin = 1'b0;
    span     = 16'h0000;
    hi_len   = 16'h0000;
    per_len  = 16'h0000;
  end
  always @(posedge clk) begin
    prev_pin <= pin;
    span     <= span + 16'h0001;
    if (pin && !prev_pin) begin
      per_len <= span;
      span    <= 16'h0001;
    end
    if (!pin && prev_pin)
      hi_len <= span;
  end
endmodule : cpw_pin_load

// ### test/tb_compare_pwm_unit.sv
/*
  self-checking bench for the compare and pwm unit.
  assumes a single ahb-lite master and a 50 MHz MCLK.
*/
`timescale 1ns/1ps
module tb_compare_pwm_unit;
  logic MCLK = 0, RESETN = 0, HSEL = 0, HWRITE = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA;
  logic [1:0] HTRANS = 0;
  logic HREADYOUT, HRESP, TICK = 0, ADC_EN = 0, TRIG, ADC_GO, PIN, IRQ;
  logic [15:0] hi_len, per_len;
  int n_errors = 0, n_tests = 0, cyc = 0, trig_n = 0, adc_n = 0;
  logic [7:0] pc[4] = '{8'h2C, 8'h2C, 8'h2C, 8'h2E};
  logic [7:0] tc[4] = '{8'h04, 8'h05, 8'h06, 8'h7C};
  logic [15:0] pp[4] = '{16'd16, 16'd64, 16'd256, 16'd16};
  logic [15:0] ph[4] = '{16'd6, 16'd24, 16'd96, 16'd10};
  logic [3:0] sm[3] = '{4'h8, 4'h9, 4'h2};
  logic [7:0] tv = 0;
  cpw_compare_pwm_unit dut_u (.MCLK(MCLK), .RESETN(RESETN), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
    .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TIMER16_TICK(TICK),
    .ADC_ENABLE(ADC_EN), .SPECIAL_TRIGGER(TRIG), .ADC_START(ADC_GO),
    .COMPARE_PWM_OUT(PIN), .UNIT_IRQ(IRQ));
  cpw_pin_load load_u (.clk(MCLK), .pin(PIN), .hi_len(hi_len),
    .per_len(per_len));
  always #10 MCLK = ~MCLK;
  ////////////////////////////////////////////////////////////////////////////
  // timeout and trigger pulse counters
  always @(posedge MCLK) begin
    cyc++;
    if (TRIG === 1'b1) trig_n++;
    if (ADC_GO === 1'b1) adc_n++;
    if (cyc == 30000) begin
      n_errors++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  function automatic logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'h0};
  endfunction : ad
  ////////////////////////////////////////////////////////////////////////////
  // bus cycles: address phase, then data phase
  task bw(input logic [7:0] i, input logic [7:0] d);
    HSEL <= 1; HADDR <= ad(i); HTRANS <= 2'h2; HWRITE <= 1;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    HSEL <= 0; HTRANS <= 2'h0; HWDATA <= {24'h0, d};
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
  endtask : bw
  task rc(input logic [7:0] i, input logic [31:0] e);
    HSEL <= 1; HADDR <= ad(i); HTRANS <= 2'h2; HWRITE <= 0;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    HSEL <= 0; HTRANS <= 2'h0;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    chk(HRDATA, e);
  endtask : rc
  // timer ticks stay synchronous to MCLK
  task tick(input int n);
    repeat (n) begin
      TICK <= 1; @(posedge MCLK); TICK <= 0;
      repeat (3) @(posedge MCLK);
      tv++;
    end
  endtask : tick
  ////////////////////////////////////////////////////////////////////////////
  // pin modes: set, clear, toggle, then mode zero
  task t_pin_modes();
    for (int k = 0; k < 3; k++) begin
      bw(cpw_pkg::IDX_CMP_LO, tv + 8'h02);
      bw(cpw_pkg::IDX_UNIT_CTRL, {4'h0, sm[k]});
      tick(2);
      chk(PIN, k != 1);
      rc(cpw_pkg::IDX_IRQ_FLAGS, 32'h20);
      bw(cpw_pkg::IDX_IRQ_FLAGS, 8'h00);
    end
    bw(cpw_pkg::IDX_UNIT_CTRL, 8'h00);
    repeat (3) @(posedge MCLK);
    chk(PIN, 1'b0);
  endtask : t_pin_modes
  // software interrupt: flag and request, pin untouched
  task t_swirq();
    bw(cpw_pkg::IDX_IRQ_EN, 8'h20);
    bw(cpw_pkg::IDX_CMP_LO, tv + 8'h03);
    bw(cpw_pkg::IDX_UNIT_CTRL, 8'h0A);
    tick(3);
    chk(IRQ, 1'b1);
    chk(PIN, 1'b0);
    bw(cpw_pkg::IDX_IRQ_FLAGS, 8'h00);
    repeat (3) @(posedge MCLK);
    chk(IRQ, 1'b0);
  endtask : t_swirq
  // special event: trigger, conversion start, delayed timer clear
  task t_special();
    bw(cpw_pkg::IDX_T16_HI, 8'hFF);
    bw(cpw_pkg::IDX_T16_LO, 8'hFC);
    bw(cpw_pkg::IDX_CMP_HI, 8'hFF);
    bw(cpw_pkg::IDX_CMP_LO, 8'hFF);
    ADC_EN <= 1;
    bw(cpw_pkg::IDX_UNIT_CTRL, 8'h0B);
    trig_n = 0; adc_n = 0;
    tick(3);
    chk(trig_n, 1);
    chk(adc_n, 1);
    rc(cpw_pkg::IDX_T16_LO, 32'hFF);
    tick(1);
    rc(cpw_pkg::IDX_T16_HI, 32'h00);
    rc(cpw_pkg::IDX_IRQ_FLAGS, 32'h20);
    // match removed before the timer edge: plain wrap sets overflow
    bw(cpw_pkg::IDX_T16_HI, 8'hFF);
    bw(cpw_pkg::IDX_T16_LO, 8'hFC);
    tick(3);
    bw(cpw_pkg::IDX_CMP_LO, 8'hFE);
    tick(1);
    rc(cpw_pkg::IDX_IRQ_FLAGS, 32'h21);
    rc(cpw_pkg::IDX_T16_LO, 32'h00);
    bw(cpw_pkg::IDX_UNIT_CTRL, 8'h00);
  endtask : t_special
  // pwm period and duty over prescales and both polarities
  task t_pwm();
    bw(cpw_pkg::IDX_PERIOD, 8'h03);
    bw(cpw_pkg::IDX_CMP_LO, 8'h01);
    for (int k = 0; k < 4; k++) begin
      bw(cpw_pkg::IDX_UNIT_CTRL, pc[k]);
      bw(cpw_pkg::IDX_TB_CTRL, tc[k]);
      repeat (6 * pp[k]) @(posedge MCLK);
      chk(per_len, pp[k]);
      chk(hi_len, ph[k]);
    end
    bw(cpw_pkg::IDX_UNIT_CTRL, 8'h2C);
    bw(cpw_pkg::IDX_CMP_LO, 8'h05);
    repeat (100) @(posedge MCLK);
    chk(PIN, 1'b1);
    repeat (7) @(posedge MCLK);
    chk(PIN, 1'b1);
    bw(cpw_pkg::IDX_CMP_HI, 8'h55);
    chk(HRESP, 32'h0);
    rc(cpw_pkg::IDX_CMP_HI, 32'h05);
    bw(cpw_pkg::IDX_UNIT_CTRL, 8'h00);
    repeat (3) @(posedge MCLK);
    chk(PIN, 1'b0);
  endtask : t_pwm
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge MCLK);
    RESETN <= 1;
    repeat (4) @(posedge MCLK);
    rc(cpw_pkg::IDX_UNIT_CTRL, 32'h00);
    rc(cpw_pkg::IDX_PERIOD, 32'hFF);
    rc(cpw_pkg::IDX_IRQ_FLAGS, 32'h00);
    rc(8'hFF, 32'h00);
    t_pin_modes();
    t_swirq();
    t_special();
    t_pwm();
    end_of_test();
  end
endmodule : tb_compare_pwm_unit
